/* core/fsr_defines.svh */
// Timing counts, register offsets and status-word fields for the flash status host.
// Assumes a single 20 MHz clock; included by bare name.
`ifndef FSR_DEFINES_SVH
`define FSR_DEFINES_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define FSR_CLK_NS 50
`define FSR_CYC_MIN(ns) (((ns) + `FSR_CLK_NS - 1) / `FSR_CLK_NS)
`define FSR_T_ACC_NS 70
`define FSR_T_WP_NS 35
`define FSR_T_HIGH_NS 20
`define FSR_ACC_CYC `FSR_CYC_MIN(`FSR_T_ACC_NS)
`define FSR_WP_CYC `FSR_CYC_MIN(`FSR_T_WP_NS)
`define FSR_HIGH_CYC `FSR_CYC_MIN(`FSR_T_HIGH_NS)
`define FSR_SYNC_CYC 2
`define FSR_POLL_MAX 16'h0400

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define FSR_REG_CMD 5'h00
`define FSR_REG_STAT 5'h04
`define FSR_REG_RESULT 5'h08
`define FSR_REG_ADDR 5'h0c
`define FSR_REG_POLL 5'h10

// ----------------------------------------
// Status word fields
// ----------------------------------------
`define FSR_BIT_READY 7
`define FSR_BIT_ESUS 6
`define FSR_BIT_ERASE 5
`define FSR_BIT_PROG 4
`define FSR_BIT_ABORT 3
`define FSR_BIT_PSUS 2
`define FSR_BIT_LOCK 1
`define FSR_BIT_CONT 0
`define FSR_VALID_MASK 16'h00fe
`define FSR_RESULT_CLR 16'h003b
`define FSR_FAIL_MASK 16'h003a

`endif

/* core/fsr_pkg.sv */
// Types shared by the flash status host and its bus-cycle engine.
// Assumes fsr_defines.svh for all numeric constants.
package fsr_pkg;
   typedef enum logic [3:0] {
      FSR_OP_NONE, FSR_OP_STATUS, FSR_OP_POLL, FSR_OP_CLEAR, FSR_OP_RESET,
      FSR_OP_ESUS, FSR_OP_PSUS, FSR_OP_ERES, FSR_OP_PRES, FSR_OP_TOGGLE
   } fsr_op_e;
   typedef logic [15:0] fsr_word_t;
endpackage

/* core/fsr_cyc_if.sv */
// Request/done handshake channel, one flash cycle per request, between the sequencer and the flash bus engine.
// Assumes both ends share ref_clk; req is held until done.
`timescale 1ns/1ps
interface fsr_cyc_if #(parameter int AW = 24);
   logic req;
   logic we;
   logic [AW-1:0] addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic done;
   modport seq (output req, output we, output addr, output wdata, input rdata, input done);
   modport eng (input req, input we, input addr, input wdata, output rdata, output done);
endinterface

/* core/fsr_cycle.sv */
// Flash bus engine: one asynchronous write or read cycle per request.
// Assumes flash data pins arrive unsynchronised; the bench resolves the dq wire.
`timescale 1ns/1ps
`include "fsr_defines.svh"
module fsr_cycle #(
   parameter int AW = 24
) (
   input wire logic ref_clk,
   input wire logic rstn,
   fsr_cyc_if.eng cyc,
   output logic flash_ce_n,
   output logic flash_oe_n,
   output logic flash_we_n,
   output logic [AW-1:0] flash_addr,
   input wire logic [15:0] flash_dq_i,
   output logic [15:0] flash_dq_o,
   output logic flash_dq_oe
);
   import fsr_pkg::*;

   localparam logic [3:0] WP_CYC = 4'(`FSR_WP_CYC);
   localparam logic [3:0] RD_CYC = 4'(`FSR_ACC_CYC + `FSR_SYNC_CYC);
   localparam logic [3:0] HI_CYC = 4'(`FSR_HIGH_CYC);

   typedef enum logic [1:0] {C_IDLE, C_ACT, C_HIGH} fsr_cst_e;
   fsr_cst_e st;
   logic [3:0] cnt;
   logic is_wr;
   logic [15:0] dq_s1;
   logic [15:0] dq_s2;

   // Read data pass two flops; the active window is stretched to cover them
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         dq_s1 <= 16'h0000;
         dq_s2 <= 16'h0000;
      end else begin
         dq_s1 <= flash_dq_i;
         dq_s2 <= dq_s1;
      end
   end

   wire cnt_end = (cnt == 4'h1);
   assign cyc.done = (st == C_HIGH) && cnt_end;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st <= C_IDLE;
         cnt <= 4'h0;
         is_wr <= 1'b0;
         flash_ce_n <= 1'b1;
         flash_oe_n <= 1'b1;
         flash_we_n <= 1'b1;
         flash_addr <= '0;
         flash_dq_o <= 16'h0000;
         flash_dq_oe <= 1'b0;
         cyc.rdata <= 16'h0000;
      end else begin
         case (st)
            C_IDLE: if (cyc.req) begin
               st <= C_ACT;
               is_wr <= cyc.we;
               cnt <= cyc.we ? WP_CYC : RD_CYC;
               flash_addr <= cyc.addr;
               flash_dq_o <= cyc.wdata;
               flash_dq_oe <= cyc.we;
               flash_ce_n <= 1'b0;
               flash_we_n <= !cyc.we;
               flash_oe_n <= cyc.we;
            end
            C_ACT: begin
               cnt <= cnt - 4'h1;
               if (cnt_end) begin
                  // Enables rise together; the high time follows in C_HIGH
                  st <= C_HIGH;
                  cnt <= HI_CYC;
                  flash_ce_n <= 1'b1;
                  flash_oe_n <= 1'b1;
                  flash_we_n <= 1'b1;
                  flash_dq_oe <= 1'b0;
                  if (!is_wr) begin
                     cyc.rdata <= dq_s2;
                  end
               end
            end
            C_HIGH: begin
               cnt <= cnt - 4'h1;
               if (cnt_end) begin
                  st <= C_IDLE;
               end
            end
            default: st <= C_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   logic [3:0] hi_cnt;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         hi_cnt <= 4'hf;
      end else if (!flash_ce_n) begin
         hi_cnt <= 4'h0;
      end else if (hi_cnt != 4'hf) begin
         hi_cnt <= hi_cnt + 4'h1;
      end
   end

   chk_enable_high_time: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      $fell(flash_ce_n) |-> $past(hi_cnt) >= HI_CYC)
      else $error("enable high time too short");
   chk_we_oe_excl: assert property (
      @(posedge ref_clk) disable iff (!rstn) !(!flash_we_n && !flash_oe_n))
      else $error("write and output enable low together");
   chk_dq_drive_win: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      flash_dq_oe |-> !flash_ce_n && !flash_we_n && flash_oe_n)
      else $error("data driven outside write pulse");
endmodule

/* core/fsr_host.sv */
// Host controller that issues status, suspend, resume and clear commands to a
// parallel flash and evaluates its status word. Software reaches it over
// Avalon-MM; the flash sits on the asynchronous pins of the bus engine.
`timescale 1ns/1ps
`include "fsr_defines.svh"
// Contract
// - Host holds chip or output enable high the minimum time after the read.
// - Bits 6 to 1 mean something only when bit 7 is 1.
// - Bits 15 to 8 are reserved and masked by the host.
// - Bit 0 is continuity indicator, otherwise reserved; host masks it.
// - After erase suspend, host polls status until ready bit is 1; host gives up after poll_max + 1 polls and sets timeout.
// - After program suspend, host polls status until ready bit is 1; host gives up after poll_max + 1 polls and sets timeout.
module fsr_host #(
   parameter int AW = 24,
   parameter logic [7:0] STS_CODE = 8'h70,
   parameter logic [7:0] CLR_CODE = 8'h71,
   parameter logic [7:0] RST_CODE = 8'hf0,
   parameter logic [7:0] ESUS_CODE = 8'hb0,
   parameter logic [7:0] ERES_CODE = 8'h30,
   parameter logic [7:0] PSUS_CODE = 8'h51,
   parameter logic [7:0] PRES_CODE = 8'h50
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic flash_ce_n,
   output logic flash_oe_n,
   output logic flash_we_n,
   output logic [AW-1:0] flash_addr,
   input wire logic [15:0] flash_dq_i,
   output logic [15:0] flash_dq_o,
   output logic flash_dq_oe,
   input wire logic ready_busy_n_output
);
   import fsr_pkg::*;

   typedef enum logic [1:0] {S_IDLE, S_CMD, S_READ, S_EVAL} fsr_st_e;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return r;
   endfunction

   // Reserved byte and bit 0 dropped; bits 6..1 dropped while busy
   function automatic fsr_word_t status_view(input fsr_word_t w);
      fsr_word_t v;
      v = w & `FSR_VALID_MASK;
      if (!w[`FSR_BIT_READY]) begin
         v[6:1] = 6'h00;
      end
      return v;
   endfunction

   function automatic logic [7:0] code_of(input fsr_op_e op);
      case (op)
         FSR_OP_CLEAR: code_of = CLR_CODE;
         FSR_OP_RESET: code_of = RST_CODE;
         FSR_OP_ESUS: code_of = ESUS_CODE;
         FSR_OP_PSUS: code_of = PSUS_CODE;
         FSR_OP_ERES: code_of = ERES_CODE;
         FSR_OP_PRES: code_of = PRES_CODE;
         default: code_of = STS_CODE;
      endcase
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   fsr_cyc_if #(.AW(AW)) cyc ();
   fsr_st_e st;
   fsr_op_e op;
   logic [7:0] cur_code;
   logic [AW-1:0] addr_reg;
   logic [15:0] poll_max;
   logic [15:0] polls;
   fsr_word_t result;
   logic res_valid;
   logic done_flag;
   logic timeout;
   logic tgl_have;
   logic tgl_prev;
   logic rd_ack;
   logic rb_s1;
   logic rb_s2;

   // ----------------------------------------
   // Avalon decode
   // ----------------------------------------
   wire busy = (st != S_IDLE);
   wire sel_cmd = (avs_address == `FSR_REG_CMD);
   wire sel_addr = (avs_address == `FSR_REG_ADDR);
   wire sel_poll = (avs_address == `FSR_REG_POLL);
   wire wr_op_ok = (avs_writedata[3:0] <= 4'(FSR_OP_TOGGLE))
                   && (avs_writedata[3:0] != 4'(FSR_OP_NONE));
   // Commands are back-pressured, not dropped, while a sequence runs
   wire cmd_stall = avs_write && sel_cmd && busy;
   wire start = avs_write && sel_cmd && !busy && avs_byteenable[0] && wr_op_ok;
   wire [3:0] new_op = avs_writedata[3:0];
   wire fail_any = |(result & `FSR_FAIL_MASK);
   wire [31:0] stat_word = {26'h0, res_valid, fail_any, rb_s2, timeout, done_flag, busy};
   wire [31:0] addr_word = 32'(addr_reg);
   wire [31:0] rd_mux = (avs_address == `FSR_REG_CMD) ? {28'h0, 4'(op)} :
                        (avs_address == `FSR_REG_STAT) ? stat_word :
                        (avs_address == `FSR_REG_RESULT) ? {16'h0, result} :
                        sel_addr ? addr_word :
                        sel_poll ? {16'h0, poll_max} : 32'h0;
   wire [31:0] addr_next = be_merge(addr_word, avs_writedata, avs_byteenable);
   wire [31:0] poll_next = be_merge({16'h0, poll_max}, avs_writedata, avs_byteenable);

   // Reads answer on the second edge from registered data
   assign avs_waitrequest = (avs_read && !rd_ack) || cmd_stall;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rd_ack <= 1'b0;
         avs_readdata <= 32'h0;
      end else begin
         rd_ack <= avs_read && !rd_ack;
         if (avs_read && !rd_ack) begin
            avs_readdata <= rd_mux;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         addr_reg <= '0;
         poll_max <= `FSR_POLL_MAX;
      end else if (avs_write && !busy) begin
         if (sel_addr) begin
            addr_reg <= addr_next[AW-1:0];
         end
         if (sel_poll) begin
            poll_max <= poll_next[15:0];
         end
      end
   end

   // Device ready/busy pin is asynchronous to ref_clk
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rb_s1 <= 1'b0;
         rb_s2 <= 1'b0;
      end else begin
         rb_s1 <= ready_busy_n_output;
         rb_s2 <= rb_s1;
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   wire op_polls = (op == FSR_OP_POLL) || (op == FSR_OP_ESUS) || (op == FSR_OP_PSUS);
   wire op_reads = op_polls || (op == FSR_OP_STATUS);
   wire op_clears = (op == FSR_OP_CLEAR) || (op == FSR_OP_RESET);
   wire rd_ready = cyc.rdata[`FSR_BIT_READY];
   wire poll_out = (polls >= poll_max);
   wire tgl_same = tgl_have && (cyc.rdata[6] == tgl_prev);

   assign cyc.req = (st == S_CMD) || (st == S_READ);
   assign cyc.we = (st == S_CMD);
   assign cyc.addr = addr_reg;
   assign cyc.wdata = {8'h00, cur_code};

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st <= S_IDLE;
         op <= FSR_OP_NONE;
         cur_code <= 8'h00;
         polls <= 16'h0000;
         result <= 16'h0080; // mirrors device reset view
         res_valid <= 1'b0;
         done_flag <= 1'b0;
         timeout <= 1'b0;
         tgl_have <= 1'b0;
         tgl_prev <= 1'b0;
      end else begin
         case (st)
            S_IDLE: if (start) begin
               op <= fsr_op_e'(new_op);
               cur_code <= code_of(fsr_op_e'(new_op));
               polls <= 16'h0000;
               done_flag <= 1'b0;
               timeout <= 1'b0;
               tgl_have <= 1'b0;
               st <= (fsr_op_e'(new_op) == FSR_OP_TOGGLE) ? S_READ : S_CMD;
            end
            S_CMD: if (cyc.done) begin
               if (op_polls && cur_code != STS_CODE) begin
                  cur_code <= STS_CODE; // suspend then poll
               end else if (op_reads) begin
                  st <= S_READ; // exactly one read follows the command
               end else begin
                  if (op_clears) begin
                     result <= result & ~`FSR_RESULT_CLR;
                  end
                  st <= S_IDLE;
                  done_flag <= 1'b1;
               end
            end
            S_READ: if (cyc.done) begin
               st <= S_EVAL;
            end
            S_EVAL: begin
               polls <= polls + 16'h0001;
               if (op == FSR_OP_TOGGLE) begin
                  // Toggle stopped means the algorithm ended
                  tgl_have <= 1'b1;
                  tgl_prev <= cyc.rdata[6];
                  st <= (tgl_same || poll_out) ? S_IDLE : S_READ;
                  done_flag <= tgl_same || poll_out;
                  timeout <= !tgl_same && poll_out;
               end else begin
                  result <= status_view(cyc.rdata);
                  res_valid <= 1'b1;
                  if (op == FSR_OP_STATUS || rd_ready || poll_out) begin
                     st <= S_IDLE;
                     done_flag <= 1'b1;
                     timeout <= !rd_ready && op != FSR_OP_STATUS;
                  end else begin
                     st <= S_CMD; // keep polling until ready
                  end
               end
            end
            default: st <= S_IDLE;
         endcase
      end
   end

   fsr_cycle #(.AW(AW)) u_cycle (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .cyc(cyc.eng),
      .flash_ce_n(flash_ce_n),
      .flash_oe_n(flash_oe_n),
      .flash_we_n(flash_we_n),
      .flash_addr(flash_addr),
      .flash_dq_i(flash_dq_i),
      .flash_dq_o(flash_dq_o),
      .flash_dq_oe(flash_dq_oe)
   );

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   chk_reserved_masked: assert property (result[15:8] == 8'h00)
      else $error("reserved byte not masked");
   chk_cont_masked: assert property (res_valid |-> !result[`FSR_BIT_CONT])
      else $error("continuity bit not masked");
   chk_busy_bits_hidden: assert property (!result[7] |-> result[6:1] == 6'h00)
      else $error("state bits shown while busy");
   chk_poll_ends_ready: assert property (
      $rose(done_flag) && op_polls && !timeout |-> result[`FSR_BIT_READY])
      else $error("poll ended before ready");
   chk_status_after_cmd: assert property (
      $rose(st == S_READ) && op != FSR_OP_TOGGLE |-> $past(cur_code) == STS_CODE)
      else $error("status read without status command");
   chk_cmd_backpress: assert property (cmd_stall |-> avs_waitrequest)
      else $error("command accepted while busy");
   chk_read_latency: assert property (
      avs_read && !rd_ack |-> avs_waitrequest ##1 (!avs_waitrequest || !avs_read))
      else $error("read answer not on second edge");
   chk_clear_result: assert property (
      st == S_CMD && cyc.done && op_clears |=> (result & `FSR_RESULT_CLR) == 16'h0)
      else $error("result bits not cleared");

   cov_poll_ready: cover property ($rose(done_flag) && op_polls && result[7]);
   cov_poll_timeout: cover property ($rose(timeout));
   cov_toggle_done: cover property ($rose(done_flag) && op == FSR_OP_TOGGLE);
endmodule

/* bench/fsr_flash_model.sv */
// Behavioural flash device: status word, one-read overlay, suspend and result flags.
// Assumes the bench resolves the data wire and starts embedded operations by task call.
`timescale 1ns/1ps
module fsr_flash_model #(
   parameter logic [7:0] STS_CODE = 8'h70,
   parameter logic [7:0] CLR_CODE = 8'h71,
   parameter logic [7:0] RST_CODE = 8'hf0,
   parameter logic [7:0] ESUS_CODE = 8'hb0,
   parameter logic [7:0] ERES_CODE = 8'h30,
   parameter logic [7:0] PSUS_CODE = 8'h51,
   parameter logic [7:0] PRES_CODE = 8'h50
) (
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic [23:0] addr,
   input wire logic [15:0] dq_in,
   input wire logic dq_oe,
   output logic [15:0] dq_out,
   output logic ready_busy_n_output
);
   // ----------------------------------------
   // Device state
   // ----------------------------------------
   logic [7:0] sr = 8'h80;
   logic [7:0] fail = 8'h00;
   logic [15:0] rnd = 16'h5a3c;
   logic [15:0] last = 16'h0000;
   logic [7:0] wbyte = 8'h00;
   logic ovl = 1'b0;
   logic tog = 1'b0;
   logic pend_es = 1'b0;
   logic pend_ps = 1'b0;
   int busy_cnt = 0;
   wire logic rd = !ce_n && !oe_n;
   wire logic wr = !ce_n && !we_n;
   // Busy hides bits 6:1 behind noise, so a host that peeks early sees garbage
   wire logic [15:0] stat_v =
      {rnd[15:8], sr[7], sr[7] ? sr[6:1] : rnd[6:1], rnd[0]};
   wire logic [15:0] arr_v = sr[7] ? addr[15:0] :
      {addr[15:8], 1'b0, tog, addr[5:3], tog, addr[1:0]};
   // Released bus shows the inverse of the last value, never a stale copy
   assign dq_out = rd ? (ovl ? stat_v : arr_v) : ~last;
   assign ready_busy_n_output = sr[7];
   always @(dq_out) if (rd) last = dq_out;
   always @* if (wr && dq_oe) wbyte = dq_in[7:0];
   task automatic finish_op();
      sr = 8'h80 | (fail & 8'h3b) | {1'b0, pend_es, 3'b000, pend_ps, 2'b00};
      pend_es = 1'b0;
      pend_ps = 1'b0;
   endtask
   // Program aimed at the erase-suspended sector is refused; it only flags failure
   task automatic prog_to_suspended();
      if (sr[6]) sr[4] = 1'b1;
   endtask
   task automatic start_op(input int n, input logic [7:0] f);
      sr = 8'h00;
      fail = f;
      busy_cnt = n;
      if (n == 0) finish_op();
   endtask
   always @(negedge wr) begin
      if (wbyte == STS_CODE) ovl = 1'b1;
      else if (wbyte == CLR_CODE) sr = sr & 8'hc4;
      else if (wbyte == RST_CODE) begin
         sr = 8'h80;
         busy_cnt = 0;
      end
      else if (wbyte == ESUS_CODE) pend_es = !sr[7];
      else if (wbyte == PSUS_CODE) pend_ps = !sr[7];
      else if (wbyte == ERES_CODE) sr[6] = 1'b0;
      else if (wbyte == PRES_CODE) sr[2] = 1'b0;
   end
   always @(negedge rd) begin
      ovl = 1'b0;
      rnd = 16'($urandom);
      if (!sr[7]) begin
         tog = ~tog;
         busy_cnt = busy_cnt - 1;
         if (busy_cnt <= 0) finish_op();
      end
   end
endmodule

/* bench/fsr_host_tb_top.sv */
// Self-checking bench for the flash status host: Avalon tasks against a device model.
// Assumes the core/ design files and bench/fsr_flash_model.sv are compiled first.
`timescale 1ns/1ps
`include "fsr_defines.svh"
module fsr_host_tb_top;
   import fsr_pkg::*;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe, rb;
   logic [23:0] flash_addr;
   logic [15:0] flash_dq_o, mdl_dq;
   wire logic [15:0] flash_dq_i = flash_dq_oe ? flash_dq_o : mdl_dq;
   int miscompares = 0;
   int n_checks = 0;
   logic [31:0] res, stat, q;
   logic [7:0] f;
   logic [23:0] adr;
   always #25 ref_clk = ~ref_clk;
   fsr_host dut (.ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
      .flash_addr(flash_addr), .flash_dq_i(flash_dq_i), .flash_dq_o(flash_dq_o),
      .flash_dq_oe(flash_dq_oe), .ready_busy_n_output(rb));
   fsr_flash_model mdl (.ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n),
      .addr(flash_addr), .dq_in(flash_dq_o), .dq_oe(flash_dq_oe), .dq_out(mdl_dq),
      .ready_busy_n_output(rb));
   task automatic summarize();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One Avalon transfer; an idle edge always precedes the request
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      // Waitrequest sampled at the rising edge; only the watchdog ends a hang
      do begin
         @(posedge ref_clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic run_op(input logic [3:0] op);
      bus(1'b1, `FSR_REG_CMD, {28'h0, op});
      do begin
         bus(1'b0, `FSR_REG_STAT, 32'h0);
      end while (q[1] !== 1'b1);
      stat = q;
      bus(1'b0, `FSR_REG_RESULT, 32'h0);
      res = q;
   endtask
   function automatic logic [31:0] exp_res(input logic [7:0] sw);
      return {24'h0, sw[7], sw[7] ? sw[6:1] : 6'h00, 1'b0};
   endfunction
   initial begin
      repeat (50000) @(posedge ref_clk);
      miscompares++;
      summarize();
   end
   initial begin
      void'($urandom(63));
      repeat (5) @(posedge ref_clk);
      rstn <= 1'b1;
      bus(1'b0, `FSR_REG_RESULT, 32'h0);
      check("result reset", q, 32'h80);
      bus(1'b0, `FSR_REG_POLL, 32'h0);
      check("poll reset", q, 32'h400);
      bus(1'b1, 5'h14, 32'hffff);
      bus(1'b0, 5'h14, 32'h0);
      check("unmapped", q, 32'h0);
      bus(1'b1, `FSR_REG_POLL, 32'h4);
      adr = 24'($urandom);
      bus(1'b1, `FSR_REG_ADDR, {8'h0, adr});
      bus(1'b0, `FSR_REG_ADDR, 32'h0);
      check("addr reg", q, {8'h0, adr});
      bus(1'b0, `FSR_REG_STAT, 32'h0);
      check("ready pin idle", 32'(q[3]), 32'h1);
      for (int i = 0; i < 6; i++) begin
         f = 8'($urandom) & 8'h3b;
         mdl.start_op(1, f);
         repeat (3) @(posedge ref_clk);
         bus(1'b0, `FSR_REG_STAT, 32'h0);
         check("busy pin", 32'(q[3]), 32'h0);
         run_op(4'h1);
         check("busy result", res, 32'h0);
         run_op(4'h1);
         check("done result", res, exp_res(8'h80 | f));
         check("fail flag", 32'(stat[4]), 32'(|(f & 8'h3a)));
         check("result valid", 32'(stat[5]), 32'h1);
         check("flash addr", 32'(flash_addr), {8'h0, adr});
      end
      mdl.start_op(0, 8'h3b);
      run_op(4'h3);
      run_op(4'h1);
      check("clear", res, 32'h80);
      for (int k = 0; k < 2; k++) begin
         mdl.start_op(3, 8'h00);
         run_op(k ? 4'h6 : 4'h5);
         check("suspend", res, k ? 32'h84 : 32'hc0);
         check("no timeout", 32'(stat[2]), 32'h0);
         if (k == 0) begin
            mdl.prog_to_suspended();
            run_op(4'h1);
            check("suspended prog", res, 32'hd0);
         end
         mdl.sr = mdl.sr | 8'h3a;
         run_op(4'h3);
         run_op(4'h1);
         check("clear keeps state", res, k ? 32'h84 : 32'hc0);
         run_op(k ? 4'h8 : 4'h7);
         run_op(4'h1);
         check("resume", res, 32'h80);
      end
      mdl.start_op(10, 8'h10);
      run_op(4'h2);
      check("poll timeout", 32'(stat[2]), 32'h1);
      check("poll busy", res, 32'h0);
      run_op(4'h9);
      check("toggle busy", 32'(stat[2]), 32'h1);
      run_op(4'h2);
      check("poll done", res, 32'h90);
      run_op(4'h9);
      check("toggle done", 32'(stat[2]), 32'h0);
      mdl.start_op(0, 8'h1a);
      run_op(4'h4);
      run_op(4'h1);
      check("reset op", res, 32'h80);
      mdl.start_op(0, 8'h02);
      bus(1'b1, `FSR_REG_CMD, 32'h1);
      run_op(4'h1);
      check("stalled cmd", res, 32'h82);
      bus(1'b1, `FSR_REG_CMD, 32'ha);
      bus(1'b0, `FSR_REG_STAT, 32'h0);
      check("ignored op", 32'(q[1:0]), 32'h2);
      summarize();
   end
endmodule
